// ===== rtl/ee_core.sv
// Purpose: Two-wire slave with 256 bytes of storage, page write and reads
// Assumes: Bus clock at most sys_clk_i/8; pins are open drain
// Notes: Writes are buffered and committed to the array after stop
`timescale 1ns/1ps
`include "ee_defines.svh"
module ee_core #(
  parameter int WR_CYCLES = `EE_WR_CYCLE_US * `EE_SYS_CLK_MHZ,
  // Device type code; value is arbitrary
  parameter logic [3:0] DEV_TYPE = 4'h5,
  parameter int FIFO_DEPTH = `EE_FIFO_DEPTH
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_b_o,
  output logic wr_busy_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int ENT_W = $bits(ee_pkg::ee_wr_ent_t);

  ee_pkg::ee_bus_ev_t ev;
  ee_pkg::ee_state_t state;
  ee_pkg::ee_state_t next_state;
  ee_pkg::ee_rx_kind_t kind;
  ee_pkg::ee_rx_kind_t next_kind;
  ee_pkg::ee_wr_ent_t ent_in;
  ee_pkg::ee_wr_ent_t ent_out;
  logic [2:0] bit_cnt;
  logic [2:0] next_bit_cnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [7:0] addr_cnt;
  logic [7:0] next_addr_cnt;
  logic [7:0] rx_byte;
  logic rw;
  logic next_rw;
  logic sda_rel;
  logic next_sda_rel;
  logic macked;
  logic next_macked;
  logic wr_pend;
  logic next_wr_pend;
  logic busy;
  logic next_busy;
  logic [31:0] wr_cnt;
  logic [31:0] next_wr_cnt;
  logic push;
  logic flush;
  logic commit;
  logic tx_load;
  logic pop;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [ENT_W-1:0] fifo_out_data;
  logic [7:0] mem [`EE_MEM_WORDS];

  // ----------------------------------------------------------------
  // Pin front end and write buffer
  // ----------------------------------------------------------------
  ee_pin_sync u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .ev_o(ev)
  );

  // Draining is held off until the write cycle, so the buffer really fills
  ee_fifo #(.WIDTH(ENT_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .flush_i(flush),
    .in_valid_i(push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(ent_in),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(busy),
    .out_data_o(fifo_out_data)
  );

  assign ent_out = fifo_out_data;
  assign ent_in = '{addr: addr_cnt, data: rx_byte};
  assign sda_o = 1'b0;
  assign sda_oe_b_o = sda_rel;
  assign wr_busy_o = busy;

  // ----------------------------------------------------------------
  // Protocol engine
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_kind = kind;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_addr_cnt = addr_cnt;
    next_rw = rw;
    next_sda_rel = sda_rel;
    next_macked = macked;
    next_wr_pend = wr_pend;
    push = 1'b0;
    flush = 1'b0;
    commit = 1'b0;
    tx_load = 1'b0;
    rx_byte = {shreg[6:0], ev.sda};
    if (busy) begin
      // Deaf while programming, so a poll address simply goes unanswered
      next_state = ee_pkg::S_IDLE;
      next_sda_rel = 1'b1;
    end else if (ev.start) begin
      next_state = ee_pkg::S_RX;
      next_kind = ee_pkg::K_DEV;
      next_bit_cnt = `EE_FIRST_BIT;
      next_sda_rel = 1'b1;
      next_wr_pend = 1'b0;
      flush = 1'b1;
    end else if (ev.stop) begin
      next_state = ee_pkg::S_IDLE;
      next_sda_rel = 1'b1;
      next_wr_pend = 1'b0;
      commit = wr_pend;
    end else begin
      case (state)
        ee_pkg::S_RX: begin
          if (ev.scl_rise) begin
            next_shreg = rx_byte;
            next_bit_cnt = 3'(bit_cnt + 1'b1);
            if (bit_cnt == `EE_LAST_BIT) begin
              case (kind)
                ee_pkg::K_DEV: begin
                  // Spare address bits are not compared
                  if (rx_byte[`EE_TYPE_MSB:`EE_TYPE_LSB] == DEV_TYPE) begin
                    next_rw = rx_byte[`EE_RW_POS];
                    next_state = ee_pkg::S_ACK;
                  end else begin
                    next_state = ee_pkg::S_IDLE;
                  end
                end
                ee_pkg::K_WORD: begin
                  next_addr_cnt = rx_byte;
                  next_state = ee_pkg::S_ACK;
                end
                default: begin
                  // A full buffer refuses the byte by withholding acknowledge
                  if (fifo_in_ready) begin
                    push = 1'b1;
                    next_addr_cnt = {addr_cnt[`EE_BYTE_MSB:`EE_PAGE_LSB_HI],
                      2'(addr_cnt[`EE_PAGE_MSB:0] + `EE_PAGE_STEP)};
                    next_wr_pend = 1'b1;
                    next_state = ee_pkg::S_ACK;
                  end else begin
                    next_state = ee_pkg::S_IDLE;
                  end
                end
              endcase
            end
          end
        end
        ee_pkg::S_ACK: begin
          if (ev.scl_fall) begin
            if (sda_rel) begin
              next_sda_rel = 1'b0;
            end else if (rw) begin
              tx_load = 1'b1;
            end else begin
              next_sda_rel = 1'b1;
              next_state = ee_pkg::S_RX;
              next_bit_cnt = `EE_FIRST_BIT;
              next_kind = (kind == ee_pkg::K_DEV) ? ee_pkg::K_WORD : ee_pkg::K_DATA;
            end
          end
        end
        ee_pkg::S_TX: begin
          if (ev.scl_fall) begin
            if (bit_cnt == `EE_LAST_BIT) begin
              next_sda_rel = 1'b1;
              next_macked = 1'b0;
              next_state = ee_pkg::S_MACK;
            end else begin
              next_bit_cnt = 3'(bit_cnt + 1'b1);
              next_shreg = {shreg[6:0], 1'b0};
              next_sda_rel = shreg[6];
            end
          end
        end
        ee_pkg::S_MACK: begin
          if (ev.scl_rise) begin
            next_macked = ~ev.sda;
          end else if (ev.scl_fall) begin
            if (macked) begin
              tx_load = 1'b1;
            end else begin
              next_state = ee_pkg::S_IDLE;
            end
          end
        end
        default: begin
          next_state = ee_pkg::S_IDLE;
        end
      endcase
      if (tx_load) begin
        next_shreg = mem[addr_cnt];
        next_sda_rel = mem[addr_cnt][`EE_BYTE_MSB];
        next_addr_cnt = 8'(addr_cnt + 1'b1);
        next_bit_cnt = `EE_FIRST_BIT;
        next_state = ee_pkg::S_TX;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      state <= ee_pkg::S_IDLE;
      kind <= ee_pkg::K_DEV;
      bit_cnt <= `EE_FIRST_BIT;
      shreg <= 8'h00;
      addr_cnt <= 8'h00;
      rw <= 1'b0;
      sda_rel <= 1'b1;
      macked <= 1'b0;
      wr_pend <= 1'b0;
    end else begin
      state <= next_state;
      kind <= next_kind;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      addr_cnt <= next_addr_cnt;
      rw <= next_rw;
      sda_rel <= next_sda_rel;
      macked <= next_macked;
      wr_pend <= next_wr_pend;
    end
  end

  // ----------------------------------------------------------------
  // Self-timed write cycle; later entries overwrite earlier ones
  // ----------------------------------------------------------------
  assign pop = busy & fifo_out_valid;

  always_comb begin
    next_busy = busy;
    next_wr_cnt = wr_cnt;
    if (commit) begin
      next_busy = 1'b1;
      next_wr_cnt = 32'(WR_CYCLES - 1);
    end else if (busy) begin
      if (wr_cnt != 32'h0000_0000) begin
        next_wr_cnt = 32'(wr_cnt - 1'b1);
      end else if (!fifo_out_valid) begin
        next_busy = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      busy <= 1'b0;
      wr_cnt <= 32'h0000_0000;
    end else begin
      busy <= next_busy;
      wr_cnt <= next_wr_cnt;
    end
  end

  // Array content survives reset, as nonvolatile storage would
  always_ff @(posedge sys_clk_i) begin
    if (pop) begin
      mem[ent_out.addr] <= ent_out.data;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  property p_busy_quiet;
    busy |-> sda_rel && state == ee_pkg::S_IDLE;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("drive while busy");

  property p_poll_nack;
    busy && ev.start |=> state == ee_pkg::S_IDLE [*2];
  endproperty
  a_poll_nack: assert property (p_poll_nack) else $error("poll answered");

  property p_commit;
    !busy && !ev.start && ev.stop && wr_pend |=> busy && wr_cnt == 32'(WR_CYCLES - 1);
  endproperty
  a_commit: assert property (p_commit) else $error("write cycle not started");

  property p_no_commit;
    !busy && !wr_pend && ev.stop |=> !busy;
  endproperty
  a_no_commit: assert property (p_no_commit) else $error("empty write cycle");

  property p_page_step;
    push |=> addr_cnt[7:2] == $past(addr_cnt[7:2])
      && addr_cnt[1:0] == 2'($past(addr_cnt[1:0]) + 2'h1);
  endproperty
  a_page_step: assert property (p_page_step) else $error("page step wrong");

  property p_page_wrap;
    push && addr_cnt[1:0] == 2'h3 |=> addr_cnt[1:0] == 2'h0;
  endproperty
  a_page_wrap: assert property (p_page_wrap) else $error("page wrap wrong");

  property p_read_step;
    tx_load |=> addr_cnt == 8'($past(addr_cnt) + 8'h01) && state == ee_pkg::S_TX
      && bit_cnt == 3'h0;
  endproperty
  a_read_step: assert property (p_read_step) else $error("read step wrong");

  property p_ack_drive;
    !busy && !ev.start && !ev.stop && state == ee_pkg::S_ACK && ev.scl_fall && sda_rel
      |=> !sda_rel ##1 !sda_rel;
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("no acknowledge");

  property p_nack_stop;
    !busy && !ev.start && !ev.stop && state == ee_pkg::S_MACK && ev.scl_fall && !macked
      |=> state == ee_pkg::S_IDLE && sda_rel;
  endproperty
  a_nack_stop: assert property (p_nack_stop) else $error("sent after nack");

  c_commit: cover property (commit);
  c_seq_read: cover property (state == ee_pkg::S_MACK && macked && ev.scl_fall);
  c_poll: cover property (busy && ev.start);
  c_wrap: cover property (push && addr_cnt[1:0] == 2'h3);

endmodule

// ===== rtl/ee_defines.svh
// Purpose: Shared constants of the serial memory slave
// Assumes: Included by bare name from the core and pin sync design files
// Notes: Timing figures are kept in their own unit, counts are derived
`ifndef EE_DEFINES_SVH
`define EE_DEFINES_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define EE_SYS_CLK_MHZ 40
`define EE_WR_CYCLE_US 5000

// ----------------------------------------------------------------
// Byte and address layout
// ----------------------------------------------------------------
`define EE_BYTE_MSB 7
`define EE_LAST_BIT 3'h7
`define EE_FIRST_BIT 3'h0
`define EE_TYPE_MSB 7
`define EE_TYPE_LSB 4
`define EE_RW_POS 0
`define EE_ADDR_W 8
`define EE_MEM_WORDS 256
`define EE_PAGE_MSB 1
`define EE_PAGE_LSB_HI 2
`define EE_PAGE_STEP 2'h1
`define EE_FIFO_DEPTH 32

`endif

// ===== rtl/ee_pkg.sv
// Purpose: Types shared by the serial memory slave
// Assumes: Nothing beyond the constants header
// Notes: Pure type definitions
package ee_pkg;

  // ----------------------------------------------------------------
  // Synchronised bus events
  // ----------------------------------------------------------------
  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
  } ee_bus_ev_t;

  // ----------------------------------------------------------------
  // Buffered write entry and protocol states
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } ee_wr_ent_t;

  typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_MACK} ee_state_t;

  typedef enum logic [1:0] {K_DEV, K_WORD, K_DATA} ee_rx_kind_t;

endpackage

// ===== rtl/ee_pin_sync.sv
// Purpose: Synchronise clock and data pins and find bus events
// Assumes: Pins are asynchronous to sys_clk_i
// Notes: Events are one-cycle pulses, two clocks after the pin moves
`timescale 1ns/1ps
`include "ee_defines.svh"
module ee_pin_sync (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output ee_pkg::ee_bus_ev_t ev_o
);

  // ----------------------------------------------------------------
  // Two-flop synchronisers, bit 1 is the clock and bit 0 the data
  // ----------------------------------------------------------------
  logic [1:0] pins;
  logic [1:0] meta;
  logic [1:0] sync;
  logic [1:0] prev;
  logic [1:0] next_meta;
  logic [1:0] next_sync;
  logic [1:0] next_prev;

  assign pins = {scl_i, sda_i};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_comb begin
        next_meta[gi] = pins[gi];
        next_sync[gi] = meta[gi];
        next_prev[gi] = sync[gi];
      end
      // Idle bus level is high, so reset to high avoids a false start
      always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
          meta[gi] <= 1'b1;
          sync[gi] <= 1'b1;
          prev[gi] <= 1'b1;
        end else begin
          meta[gi] <= next_meta[gi];
          sync[gi] <= next_sync[gi];
          prev[gi] <= next_prev[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Edge and condition decode, only from the second stage onward
  // ----------------------------------------------------------------
  always_comb begin
    ev_o.scl_rise = sync[1] & ~prev[1];
    ev_o.scl_fall = ~sync[1] & prev[1];
    ev_o.start = sync[1] & prev[1] & ~sync[0] & prev[0];
    ev_o.stop = sync[1] & prev[1] & sync[0] & ~prev[0];
    ev_o.sda = sync[0];
  end

endmodule

// ===== rtl/ee_fifo.sv
// Purpose: Write buffer between the bus front end and the array
// Assumes: DEPTH is a power of two
// Notes: Flush drops all entries in one cycle
`timescale 1ns/1ps
module ee_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  // ----------------------------------------------------------------
  // Pointer and fill tracking
  // ----------------------------------------------------------------
  assign in_ready_o = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o = store[rd_ptr];

  always_comb begin
    push = in_valid_i & in_ready_o;
    pop = out_valid_o & out_ready_i;
    next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
    next_count = (AW+1)'(count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    if (flush_i) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count = '0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // Storage carries no reset, only entries below count are ever read
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      store[wr_ptr] <= in_data_i;
    end
  end

endmodule

// ===== dv/ee_mst.sv
// Purpose: Two-wire bus master model that drives the link clock
// Assumes: Open drain data wire with pull-up, resolved by the bench
// Notes: Link clock 200 ns = 8 sys clocks, low 5 high 3, idle high
`timescale 1ns/1ps
module ee_mst (
  input wire logic sys_clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_b_o
);
  initial begin
    scl_o = 1'b1;
    sda_oe_b_o = 1'b1;
  end

  // ----------------------------------------------------------------
  // Bit level
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  // Sample at end of high: the slave answers three clocks after a fall
  task automatic bit_io(input logic b, output logic r);
    tick(1);
    sda_oe_b_o = b;
    tick(4);
    scl_o = 1'b1;
    tick(3);
    r = sda_i;
    scl_o = 1'b0;
  endtask

  // Start or repeated start; waits out a slave ack release first
  task automatic st();
    tick(3);
    sda_oe_b_o = 1'b1;
    tick(3);
    scl_o = 1'b1;
    tick(4);
    sda_oe_b_o = 1'b0;
    tick(4);
    scl_o = 1'b0;
  endtask

  task automatic sp();
    tick(3);
    sda_oe_b_o = 1'b0;
    tick(3);
    scl_o = 1'b1;
    tick(4);
    sda_oe_b_o = 1'b1;
    tick(4);
  endtask

  // ----------------------------------------------------------------
  // Byte level, MSB first
  // ----------------------------------------------------------------
  task automatic wb(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  task automatic rb(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(~mack, r);
  endtask
endmodule

// ===== dv/tb_top.sv
// Purpose: Self-checking bench for the serial memory slave
// Assumes: Master model drives the link; write cycle cut to 200 clocks
// Notes: Only written addresses are read, the array is not reset
`timescale 1ns/1ps
module tb_top;
  // Device type code; value is arbitrary
  localparam logic [3:0] DEV = 4'h5;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic scl, m_oe_b, sda_w, c_sda, c_oe_b, wr_busy, a;
  logic [7:0] d;
  int fails = 0;
  int checked = 0;

  // Open drain wire with pull-up
  assign sda_w = (!m_oe_b || (!c_oe_b && !c_sda)) ? 1'b0 : 1'b1;
  always #12.5 sys_clk = ~sys_clk;

  ee_core #(.WR_CYCLES(200), .DEV_TYPE(DEV), .FIFO_DEPTH(32)) u_ee_core (
    .sys_clk_i(sys_clk), .rst_b_i(rst_b), .scl_i(scl), .sda_i(sda_w),
    .sda_o(c_sda), .sda_oe_b_o(c_oe_b), .wr_busy_o(wr_busy));
  ee_mst u_ee_mst (.sys_clk_i(sys_clk), .sda_i(sda_w), .scl_o(scl), .sda_oe_b_o(m_oe_b));

  // ----------------------------------------------------------------
  // Compare and helper tasks
  // ----------------------------------------------------------------
  task automatic ck_bit(input logic got, input logic exp, input string s);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %b exp %b", $time, s, got, exp);
    end
  endtask

  task automatic ck_byte(input logic [7:0] got, input logic [7:0] exp, input string s);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Reserved address bits set to a non-zero pattern on purpose
  function automatic logic [7:0] sa(input logic rd);
    return {DEV, 3'h5, rd};
  endfunction

  task automatic wa(input logic [7:0] b, input logic exp);
    u_ee_mst.wb(b, a);
    ck_bit(a, exp, "ack");
  endtask

  task automatic rd(input logic mack, input logic [7:0] exp);
    u_ee_mst.rb(mack, d);
    ck_byte(d, exp, "read");
  endtask

  task automatic hdr(input logic [7:0] word);
    u_ee_mst.st();
    wa(sa(1'b0), 1'b1);
    wa(word, 1'b1);
  endtask

  // Bounded wait; running out ends the run
  task automatic wait_busy(input logic lvl, input int n);
    int k;
    k = 0;
    while (wr_busy !== lvl && k < n) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    ck_bit(wr_busy, lvl, "busy level");
    if (wr_busy !== lvl) begin
      report_and_stop();
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_badtype();
    u_ee_mst.st();
    wa({DEV ^ 4'h3, 3'h5, 1'b0}, 1'b0);
    u_ee_mst.sp();
    $display("bad type done");
  endtask

  // Six bytes from 0D wrap: C=44 D=55 E=66 F=33
  task automatic t_page();
    hdr(8'h0D);
    for (int i = 0; i < 6; i++) begin
      wa(8'(8'h11 * (i + 1)), 1'b1);
    end
    u_ee_mst.sp();
    wait_busy(1'b1, 10);
    $display("page write done");
  endtask

  task automatic t_poll();
    u_ee_mst.st();
    wa(sa(1'b0), 1'b0);
    wa(8'h0C, 1'b0);
    wa(8'hEE, 1'b0);
    u_ee_mst.sp();
    for (int k = 0; k < 40; k++) begin
      u_ee_mst.st();
      u_ee_mst.wb(sa(1'b0), a);
      if (a === 1'b1) begin
        break;
      end
      u_ee_mst.sp();
    end
    ck_bit(a, 1'b1, "poll ack");
    ck_bit(wr_busy, 1'b0, "idle at ack");
    if (a !== 1'b1) begin
      report_and_stop();
    end
    wa(8'h0C, 1'b1);
    u_ee_mst.st();
    wa(sa(1'b1), 1'b1);
    rd(1'b0, 8'h44);
    u_ee_mst.sp();
    u_ee_mst.st();
    wa(sa(1'b1), 1'b1);
    rd(1'b0, 8'h55);
    u_ee_mst.sp();
    $display("poll and random read done");
  endtask

  task automatic t_seq();
    hdr(8'h0E);
    u_ee_mst.sp();
    repeat (20) @(posedge sys_clk);
    #1;
    ck_bit(wr_busy, 1'b0, "no write cycle");
    u_ee_mst.st();
    wa(sa(1'b1), 1'b1);
    rd(1'b1, 8'h66);
    rd(1'b0, 8'h33);
    rd(1'b0, 8'hFF);
    u_ee_mst.sp();
    $display("sequential read done");
  endtask

  // Five bytes from FC wrap inside the page and leave 00 alone
  task automatic t_wrap();
    hdr(8'h00);
    wa(8'hB0, 1'b1);
    u_ee_mst.sp();
    wait_busy(1'b1, 10);
    wait_busy(1'b0, 600);
    hdr(8'hFC);
    for (int i = 0; i < 5; i++) begin
      wa(8'hA0 + 8'(i), 1'b1);
    end
    u_ee_mst.sp();
    wait_busy(1'b1, 10);
    wait_busy(1'b0, 600);
    hdr(8'hFE);
    u_ee_mst.st();
    wa(sa(1'b1), 1'b1);
    rd(1'b1, 8'hA2);
    rd(1'b1, 8'hA3);
    rd(1'b0, 8'hB0);
    u_ee_mst.sp();
    $display("wrap done");
  endtask

  initial begin
    repeat (5) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    repeat (4) @(posedge sys_clk);
    t_badtype();
    t_page();
    t_poll();
    t_seq();
    t_wrap();
    report_and_stop();
  end
endmodule
